// >>> hw/tmr2_unit.sv
/*
 Second timer/counter: 16-bit count, capture, auto-reload up/down, baud
 generator and 50% clock output, with its flags and a level interrupt.
 Assumes pin inputs already synchronous to clock; the clock stands for the
 oscillator, so clock-out is fosc / (4 x (65536 - reload)).
*/
`default_nettype none
module tmr2_unit
   import tmr2_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire tmr2_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic clkout_pin_i,
   output logic clkout_pin_o,
   output logic clkout_pin_oe_n,
   input wire logic ext_control_pin,
   input wire logic other_timer_ovf,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   output logic irq
);
   logic [7:0] ctrl_q;
   logic [1:0] mode_q;
   logic [WIDTH-1:0] reload_q;
   logic [WIDTH-1:0] count_q;
   logic [1:0] istat_q;
   logic [1:0] imask_q;
   logic [3:0] pre_q;
   logic t2_in_q;
   logic ext_in_q;
   logic clkout_q;
   logic [7:0] rdata_q;

   logic run, cnt_sel, cap_sel, exen, rxsel, txsel, baud_mode, clkout_mode, down_count_enable;
   logic tick, int_tick, pin_fall, ext_fall, up, overflow, underflow, roll;
   logic ext_event, capture_ev, ovf_set, ext_set;
   logic wr_ctrl, wr_mode, wr_rlo, wr_rhi, wr_clo, wr_chi, wr_stat, wr_mask;

   function automatic logic hit(input tmr2_bus_req_t r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   assign run = ctrl_q[TMR2_RUN_BIT];
   assign cnt_sel = ctrl_q[TMR2_CNTSEL_BIT];
   assign cap_sel = ctrl_q[TMR2_CAPSEL_BIT];
   assign exen = ctrl_q[TMR2_EXEN_BIT];
   assign rxsel = ctrl_q[TMR2_RXCLK_BIT];
   assign txsel = ctrl_q[TMR2_TXCLK_BIT];
   assign down_count_enable = mode_q[TMR2_DOWN_COUNT_ENABLE_BIT];
   assign baud_mode = rxsel | txsel;
   // clock-out needs the timer source; with counter_select set the pin is an input
   assign clkout_mode = mode_q[TMR2_CLKOE_BIT] & ~cnt_sel;

   assign wr_ctrl = hit(bus_req, TMR2_CTRL_ADDR);
   assign wr_mode = hit(bus_req, TMR2_MODE_ADDR);
   assign wr_rlo = hit(bus_req, TMR2_RLD_LO_ADDR);
   assign wr_rhi = hit(bus_req, TMR2_RLD_HI_ADDR);
   assign wr_clo = hit(bus_req, TMR2_CNT_LO_ADDR);
   assign wr_chi = hit(bus_req, TMR2_CNT_HI_ADDR);
   assign wr_stat = hit(bus_req, TMR2_IRQ_STAT_ADDR);
   assign wr_mask = hit(bus_req, TMR2_IRQ_MASK_ADDR);

   // prescaler: twelve for the plain timer, two in baud or clock-out mode
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pre_q <= 4'h0;
      else if (!run || int_tick)
         pre_q <= 4'h0;
      else
         pre_q <= pre_q + 4'h1;
   end

   always_comb
   begin
      if (baud_mode || clkout_mode)
         int_tick = run && (pre_q == 4'(TMR2_FAST_DIV - 1));
      else
         int_tick = run && (pre_q == 4'(TMR2_PRESCALE - 1));
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         t2_in_q <= 1'b1;
         ext_in_q <= 1'b1;
      end
      else
      begin
         t2_in_q <= clkout_pin_i;
         ext_in_q <= ext_control_pin;
      end
   end

   assign pin_fall = t2_in_q & ~clkout_pin_i;
   assign ext_fall = ext_in_q & ~ext_control_pin;
   assign tick = run && (cnt_sel ? pin_fall : int_tick);

   // count direction only from ext_control_pin in up/down auto-reload
   assign up = !(down_count_enable && !cap_sel && !baud_mode) || ext_control_pin;
   assign overflow = tick && up && (count_q == TMR2_CNT_MAX);
   assign underflow = tick && !up && (count_q == reload_q);
   assign roll = overflow | underflow;
   // external events ignored while the timer clocks the serial port
   assign ext_event = exen && ext_fall && !baud_mode && !(down_count_enable && !cap_sel);
   assign capture_ev = ext_event && cap_sel;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         count_q <= TMR2_WORD_RST;
      else if (wr_clo)
         count_q <= {count_q[WIDTH-1:8], bus_req.wdata};
      else if (wr_chi)
         count_q <= {bus_req.wdata, count_q[7:0]};
      else if (underflow)
         count_q <= TMR2_CNT_MAX;
      else if (overflow && (!cap_sel || baud_mode || clkout_mode))
         count_q <= reload_q;
      else if (ext_event && !cap_sel)
         count_q <= reload_q;
      else if (tick)
         count_q <= up ? count_q + 16'h0001 : count_q - 16'h0001;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reload_q <= TMR2_WORD_RST;
      else if (capture_ev)
         reload_q <= count_q;
      else if (wr_rlo)
         reload_q <= {reload_q[WIDTH-1:8], bus_req.wdata};
      else if (wr_rhi)
         reload_q <= {bus_req.wdata, reload_q[7:0]};
   end

   assign ovf_set = overflow && !baud_mode && !clkout_mode;
   // in up/down mode external_flag toggles as a seventeenth bit
   assign ext_set = ext_event;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_q <= TMR2_CTRL_RST;
      else
      begin
         if (wr_ctrl)
            ctrl_q <= bus_req.wdata;
         if (ovf_set)
            ctrl_q[TMR2_OVF_BIT] <= 1'b1;
         if (ext_set)
            ctrl_q[TMR2_EXT_BIT] <= 1'b1;
         else if (roll && down_count_enable && !cap_sel && !baud_mode)
            ctrl_q[TMR2_EXT_BIT] <= ~ctrl_q[TMR2_EXT_BIT];
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mode_q <= TMR2_MODE_RST;
      else if (wr_mode)
         mode_q <= bus_req.wdata[1:0];
   end

   // sticky status: bit1 overflow, bit0 external; set wins over clear
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         istat_q <= 2'h0;
      else
         istat_q <= (istat_q & ~(wr_stat ? bus_req.wdata[1:0] : 2'h0))
            | {ovf_set, ext_set && !down_count_enable};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         imask_q <= 2'h0;
      else if (wr_mask)
         imask_q <= bus_req.wdata[1:0];
   end

   assign irq = |(istat_q & imask_q);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         clkout_q <= 1'b0;
      else if (!clkout_mode)
         clkout_q <= 1'b0;
      else if (overflow)
         clkout_q <= ~clkout_q;
   end

   assign clkout_pin_o = clkout_q;
   assign clkout_pin_oe_n = ~clkout_mode;
   assign rx_baud_tick = rxsel ? overflow : other_timer_ovf;
   assign tx_baud_tick = txsel ? overflow : other_timer_ovf;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 8'h00;
      else if (!bus_req.rd)
         rdata_q <= 8'h00;
      else if (bus_req.addr == TMR2_CTRL_ADDR)
         rdata_q <= ctrl_q;
      else if (bus_req.addr == TMR2_MODE_ADDR)
         rdata_q <= {6'h00, mode_q};
      else if (bus_req.addr == TMR2_RLD_LO_ADDR)
         rdata_q <= reload_q[7:0];
      else if (bus_req.addr == TMR2_RLD_HI_ADDR)
         rdata_q <= reload_q[WIDTH-1:8];
      else if (bus_req.addr == TMR2_CNT_LO_ADDR)
         rdata_q <= count_q[7:0];
      else if (bus_req.addr == TMR2_CNT_HI_ADDR)
         rdata_q <= count_q[WIDTH-1:8];
      else if (bus_req.addr == TMR2_IRQ_STAT_ADDR)
         rdata_q <= {6'h00, istat_q};
      else if (bus_req.addr == TMR2_IRQ_MASK_ADDR)
         rdata_q <= {6'h00, imask_q};
      else
         rdata_q <= 8'h00;
   end

   assign rdata = rdata_q;
endmodule
`default_nettype wire

// >>> hw/tmr2_pkg.sv
/*
 Package for the second timer/counter with clock output: register offsets,
 control and mode field positions, reset values and timing constants.
 Assumes a plain register port with 8-bit registers at their printed offsets.
*/
`default_nettype none
package tmr2_pkg;
   localparam logic [7:0] TMR2_CTRL_ADDR = 8'hC8;
   localparam logic [7:0] TMR2_MODE_ADDR = 8'hC9;
   localparam logic [7:0] TMR2_RLD_LO_ADDR = 8'hCA;
   localparam logic [7:0] TMR2_RLD_HI_ADDR = 8'hCB;
   localparam logic [7:0] TMR2_CNT_LO_ADDR = 8'hCC;
   localparam logic [7:0] TMR2_CNT_HI_ADDR = 8'hCD;
   localparam logic [7:0] TMR2_IRQ_STAT_ADDR = 8'hD0;
   localparam logic [7:0] TMR2_IRQ_MASK_ADDR = 8'hD1;

   localparam int TMR2_OVF_BIT = 7;
   localparam int TMR2_EXT_BIT = 6;
   localparam int TMR2_RXCLK_BIT = 5;
   localparam int TMR2_TXCLK_BIT = 4;
   localparam int TMR2_EXEN_BIT = 3;
   localparam int TMR2_RUN_BIT = 2;
   localparam int TMR2_CNTSEL_BIT = 1;
   localparam int TMR2_CAPSEL_BIT = 0;
   localparam int TMR2_CLKOE_BIT = 1;
   localparam int TMR2_DOWN_COUNT_ENABLE_BIT = 0;

   localparam logic [7:0] TMR2_CTRL_RST = 8'h00;
   localparam logic [1:0] TMR2_MODE_RST = 2'h0;
   localparam logic [15:0] TMR2_WORD_RST = 16'h0000;
   localparam logic [15:0] TMR2_CNT_MAX = 16'hFFFF;

   // internal timer tick every twelve oscillator periods
   localparam int TMR2_PRESCALE = 12;
   // baud and clock-out modes tick at half the oscillator rate
   localparam int TMR2_FAST_DIV = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmr2_bus_req_t;
endpackage
`default_nettype wire

// >>> sim/tmr2_unit_monitor.sv
/*
 checker for the second timer port behaviour
 assumes one clock domain, bound to tmr2_unit
*/
`default_nettype none
module tmr2_unit_monitor
   import tmr2_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire tmr2_bus_req_t bus_req,
   input wire logic clkout_pin_o,
   input wire logic clkout_pin_oe_n,
   input wire logic other_timer_ovf,
   input wire logic rx_baud_tick,
   input wire logic tx_baud_tick,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl_q;
   logic [7:0] mask_q;
   logic [15:0] rld_q;
   logic [15:0] gap_q;
   logic oe_q;
   logic arm_q;
   logic co;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   assign co = oe_q && ctl_q[2] && !ctl_q[1];
   // shadow of software-owned bits only; flags live in the design
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         ctl_q <= 8'h00;
         mask_q <= 8'h00;
         rld_q <= 16'h0000;
         oe_q <= 1'b0;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == TMR2_CTRL_ADDR) ctl_q <= bus_req.wdata;
         if (bus_req.addr == TMR2_MODE_ADDR) oe_q <= bus_req.wdata[1];
         if (bus_req.addr == TMR2_RLD_LO_ADDR) rld_q[7:0] <= bus_req.wdata;
         if (bus_req.addr == TMR2_RLD_HI_ADDR) rld_q[15:8] <= bus_req.wdata;
         if (bus_req.addr == TMR2_IRQ_MASK_ADDR) mask_q <= bus_req.wdata;
      end
   // any write may retune the divider, so the first gap after it is not judged
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         gap_q <= 16'h0000;
         arm_q <= 1'b0;
      end
      else
      begin
         gap_q <= $changed(clkout_pin_o) ? 16'h0000 : gap_q + 16'h0001;
         arm_q <= bus_req.wr ? 1'b0 : (arm_q || $changed(clkout_pin_o));
      end
   property p_rx_src; !ctl_q[5] |-> rx_baud_tick == other_timer_ovf; endproperty
   a_rx_src: assert property (p_rx_src) else $error("rx tick source");
   property p_tx_src; !ctl_q[4] |-> tx_baud_tick == other_timer_ovf; endproperty
   a_tx_src: assert property (p_tx_src) else $error("tx tick source");
   property p_shared; ctl_q[5] && ctl_q[4] |-> rx_baud_tick == tx_baud_tick; endproperty
   a_shared: assert property (p_shared) else $error("rx and tx rates differ");
   property p_drive; clkout_pin_oe_n == !(oe_q && !ctl_q[1]); endproperty
   a_drive: assert property (p_drive) else $error("pin drive enable");
   // leaving clock-out parks the pin low, so only a driven pin must hold still
   property p_stop; !ctl_q[2] && !$past(ctl_q[2]) && !clkout_pin_oe_n && !$past(clkout_pin_oe_n)
      |-> $stable(clkout_pin_o); endproperty
   a_stop: assert property (p_stop) else $error("clock out moved while stopped");
   property p_period; arm_q && co && $changed(clkout_pin_o) |-> 32'(gap_q) + 1 == 2 * (65536 - 32'(rld_q)); endproperty
   a_period: assert property (p_period) else $error("clock out half period");
   property p_no_irq; co && !ctl_q[3] && !$past(bus_req.wr) |-> !$rose(irq); endproperty
   a_no_irq: assert property (p_no_irq) else $error("rollover raised irq");
   property p_mask; mask_q[1:0] == 2'h0 |-> !irq; endproperty
   a_mask: assert property (p_mask) else $error("irq while masked");
endmodule
bind tmr2_unit tmr2_unit_monitor mon (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
   .clkout_pin_o(clkout_pin_o), .clkout_pin_oe_n(clkout_pin_oe_n), .other_timer_ovf(other_timer_ovf),
   .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq));
`default_nettype wire

// >>> sim/tmr2_peer.sv
/*
 far side: pulled-up port pin and the other timer's overflow pulses
 assumes the bench pulls the pin low only while the unit is not driving
*/
`default_nettype none
module tmr2_peer
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pull_low,
   input wire logic clkout_pin_o,
   input wire logic clkout_pin_oe_n,
   output logic pin_level,
   output logic other_timer_ovf
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_q;
   assign pin_level = clkout_pin_oe_n ? !pull_low : clkout_pin_o;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         div_q <= 3'h0;
      else
         div_q <= div_q + 3'h1;
   assign other_timer_ovf = div_q == 3'h6;
endmodule
`default_nettype wire

// >>> sim/tmr2_unit_tb.sv
/*
 bench for tmr2_unit: register tasks and mode sequences
 assumes the peer model and the bound checker
*/
`default_nettype none
module tmr2_unit_tb
   import tmr2_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   tmr2_bus_req_t bus_req = '0;
   logic ext = 1'b1;
   logic pull_low = 1'b0;
   logic [7:0] rdata;
   logic pin_o, oe_n, pin, ovf, rx, tx, irq, p;
   int n_errors = 0;
   int n_tests = 0;
   int k, t, u;
   always #4 clock = ~clock;
   tmr2_unit dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .clkout_pin_i(pin),
      .clkout_pin_o(pin_o), .clkout_pin_oe_n(oe_n), .ext_control_pin(ext), .other_timer_ovf(ovf),
      .rx_baud_tick(rx), .tx_baud_tick(tx), .irq(irq));
   tmr2_peer peer (.clock(clock), .rst_n(rst_n), .pull_low(pull_low), .clkout_pin_o(pin_o),
      .clkout_pin_oe_n(oe_n), .pin_level(pin), .other_timer_ovf(ovf));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req <= '0;
      #1 check(rdata & m, exp);
   endtask
   task automatic complete_run;
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      for (k = 'hC8; k <= 'hD1; k++)
         rd(8'(k), 8'h00, 8'hFF);
      wr(TMR2_CTRL_ADDR, 8'h04);
      repeat (118) @(posedge clock);
      wr(TMR2_CTRL_ADDR, 8'h00);
      repeat (30) @(posedge clock);
      rd(TMR2_CNT_LO_ADDR, 8'h0A, 8'hFE);
      wr(TMR2_CNT_LO_ADDR, 8'h00);
      wr(TMR2_CTRL_ADDR, 8'h06);
      repeat (5)
      begin
         pull_low <= 1'b1;
         repeat (3) @(posedge clock);
         pull_low <= 1'b0;
         repeat (3) @(posedge clock);
      end
      rd(TMR2_CNT_LO_ADDR, 8'h05, 8'hFF);
      wr(TMR2_RLD_LO_ADDR, 8'hF0);
      wr(TMR2_RLD_HI_ADDR, 8'hFF);
      wr(TMR2_CNT_LO_ADDR, 8'hF0);
      wr(TMR2_CNT_HI_ADDR, 8'hFF);
      wr(TMR2_IRQ_MASK_ADDR, 8'h03);
      wr(TMR2_CTRL_ADDR, 8'h04);
      repeat (216) @(posedge clock);
      rd(TMR2_CTRL_ADDR, 8'h80, 8'h80);
      rd(TMR2_CNT_HI_ADDR, 8'hFF, 8'hFF);
      check(8'(irq), 8'h01);
      wr(TMR2_CTRL_ADDR, 8'h24);
      wr(TMR2_IRQ_STAT_ADDR, 8'h02);
      repeat (10) @(posedge clock);
      t = 0;
      u = 0;
      repeat (96)
      begin
         @(posedge clock);
         #1 t += int'(rx);
         u += int'(tx);
      end
      check(8'(t), 8'h03);
      check(8'(u), 8'h0C);
      rd(TMR2_CTRL_ADDR, 8'h00, 8'h80);
      wr(TMR2_CTRL_ADDR, 8'h00);
      wr(TMR2_MODE_ADDR, 8'h02);
      wr(TMR2_CTRL_ADDR, 8'h34);
      repeat (20) @(posedge clock);
      t = 0;
      p = pin_o;
      repeat (640)
      begin
         @(posedge clock);
         #1 t += int'(pin_o !== p);
         p = pin_o;
      end
      check(8'(t), 8'h14);
      check({7'h00, oe_n, irq}, 8'h00);
      wr(TMR2_CTRL_ADDR, 8'h00);
      wr(TMR2_MODE_ADDR, 8'h00);
      wr(TMR2_RLD_HI_ADDR, 8'h00);
      wr(TMR2_IRQ_MASK_ADDR, 8'h01);
      wr(TMR2_CTRL_ADDR, 8'h0D);
      ext <= 1'b0;
      repeat (4) @(posedge clock);
      rd(TMR2_CTRL_ADDR, 8'h40, 8'h40);
      rd(TMR2_RLD_HI_ADDR, 8'hFF, 8'hFF);
      check(8'(irq), 8'h01);
      ext <= 1'b1;
      wr(TMR2_CTRL_ADDR, 8'h00);
      wr(TMR2_IRQ_STAT_ADDR, 8'h01);
      rd(TMR2_CTRL_ADDR, 8'h00, 8'h40);
      wr(TMR2_MODE_ADDR, 8'h01);
      wr(TMR2_CTRL_ADDR, 8'h0C);
      ext <= 1'b0;
      repeat (8) @(posedge clock);
      check(8'(irq), 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
